/* File: include/strap_regs.svh */
// constants for the supervisor trap and interrupt control block
// assumes inclusion by the design files and the bench only
`ifndef STRAP_REGS_SVH
`define STRAP_REGS_SVH

// ----------------------------------------------------------------
// register numbers on the csr port
// ----------------------------------------------------------------
`define CSR_STATUS_IDX     8'h00
`define CSR_VECTOR_IDX     8'h01
`define CSR_ENABLES_IDX    8'h02
`define CSR_PENDING_IDX    8'h03
`define CSR_CNTEN_IDX      8'h04

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define ST_GIE_BIT         1
`define ST_SPIE_BIT        5
`define ST_UEND_BIT        6
`define ST_SPP_BIT         8
`define ST_LPAD_BIT        23
`define ST_TDIS_BIT        24

// ----------------------------------------------------------------
// interrupt bit positions (cause numbers)
// ----------------------------------------------------------------
`define IRQ_SOFT_BIT       1
`define IRQ_TIMER_BIT      5
`define IRQ_EXT_BIT        9
`define IRQ_COVF_BIT       13

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define DOUBLE_TRAP_CODE   64'h0000000000000010
`define VEC_RESET          64'h0000000000000000
`define CNTEN_RESET        32'h00000000

`endif

/* File: include/strap_pkg.sv */
// types for the supervisor trap and interrupt control block
// assumes the constants header is on the include path
package strap_pkg;

  // ----------------------------------------------------------------
  // privilege, access kind, vector mode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PRIV_USER = 2'h0,
    PRIV_SUPV = 2'h1,
    PRIV_MACH = 2'h3
  } priv_e;

  typedef enum logic [1:0] {
    ACC_FETCH    = 2'h0,
    ACC_DATA     = 2'h1,
    ACC_IMPLICIT = 2'h2
  } acc_kind_e;

  typedef enum logic [1:0] {
    VEC_DIRECT   = 2'h0,
    VEC_VECTORED = 2'h1
  } vec_mode_e;

endpackage : strap_pkg

/* File: design/level_sync.sv */
// two-stage synchroniser for a group of levels
// assumes the inputs come from outside the MCLK domain
`timescale 1ns/100ps
module level_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // ----------------------------------------------------------------
  // stage chain
  // ----------------------------------------------------------------
  always_comb begin
    meta_nxt = d_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign q_out = sync_r;

endmodule : level_sync

/* File: design/irq_select.sv */
// fixed-priority pick among the standard supervisor interrupts
// assumes qualified pending-and-enabled bits from the same clock
`timescale 1ns/100ps
module irq_select (
  // qualified requests
  input  wire logic [15:0] req,
  // choice
  output logic             hit,
  output logic [5:0]       cause
);

  `include "strap_regs.svh"

  // ----------------------------------------------------------------
  // external, software, timer, counter overflow
  // ----------------------------------------------------------------
  always_comb begin
    hit   = 1'b1;
    cause = 6'h00;
    if (req[`IRQ_EXT_BIT]) begin
      cause = 6'(`IRQ_EXT_BIT);
    end else if (req[`IRQ_SOFT_BIT]) begin
      cause = 6'(`IRQ_SOFT_BIT);
    end else if (req[`IRQ_TIMER_BIT]) begin
      cause = 6'(`IRQ_TIMER_BIT);
    end else if (req[`IRQ_COVF_BIT]) begin
      cause = 6'(`IRQ_COVF_BIT);
    end else begin
      hit = 1'b0;
    end
  end

endmodule : irq_select

/* File: design/supervisor_trap_interrupt_ctrl.sv */
// supervisor trap, interrupt and counter-gating control for one hart
// assumes pipeline signals on MCLK, controller levels asynchronous
`timescale 1ns/100ps
module supervisor_trap_interrupt_ctrl
  import strap_pkg::*;
#(
  parameter bit HAS_COUNTER_OVF = 1'b1
) (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        ARST_N,
  // csr port
  input  wire logic        CSR_WR,
  input  wire logic        CSR_RD,
  input  wire logic [7:0]  CSR_ADDR,
  input  wire logic [63:0] CSR_WDATA,
  output logic      [63:0] CSR_RDATA,
  // hart state
  input  wire logic [1:0]  PRIV,
  input  wire logic        VIRT,
  input  wire logic        SUPV_BIG_ENDIAN,
  // memory access endianness
  input  wire logic        ACC_REQ,
  input  wire logic [1:0]  ACC_KIND,
  output logic             ACC_BIG_ENDIAN,
  // trap request and answer
  input  wire logic        TRAP_REQ,
  input  wire logic        TRAP_TO_SUPV,
  input  wire logic        TRAP_IS_INT,
  input  wire logic [5:0]  TRAP_CODE,
  input  wire logic        SRET,
  output logic             TRAP_TAKE_SUPV,
  output logic             TRAP_TAKE_MACH,
  output logic      [63:0] TRAP_PC,
  output logic      [63:0] MACH_CAUSE,
  output logic      [63:0] SECONDARY_TRAP_VALUE,
  // landing-pad state copies
  input  wire logic        LPAD_MACH_IN,
  input  wire logic        LPAD_VIRT_IN,
  output logic             LPAD_MACH_WE,
  output logic             LPAD_VIRT_WE,
  output logic             LPAD_WDATA,
  // interrupt sources
  input  wire logic        EXT_INT_LEVEL,
  input  wire logic        TIMER_INT_LEVEL,
  input  wire logic        SOFT_INT_SET,
  input  wire logic        COUNTER_OVF_SET,
  output logic             IRQ_TAKE,
  output logic      [5:0]  IRQ_CAUSE,
  // counter read gating
  input  wire logic        CNT_RD,
  input  wire logic [4:0]  CNT_INDEX,
  input  wire logic [31:0] MACH_CNT_EN,
  output logic             CNT_ILLEGAL
);

  `include "strap_regs.svh"

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic        gie_r, gie_nxt;
  logic        spie_r, spie_nxt;
  logic        spp_r, spp_nxt;
  logic        user_big_endian_r, user_big_endian_nxt;
  logic        supervisor_trap_disable_r, supervisor_trap_disable_nxt;
  logic [63:2] vec_base_r, vec_base_nxt;
  logic [1:0]  vec_mode_r, vec_mode_nxt;
  logic        software_int_pending_r, software_int_pending_nxt;
  logic        counter_overflow_int_pending_r;
  logic        counter_overflow_int_pending_nxt;
  logic [15:0] enables_r, enables_nxt;
  logic [31:0] cnt_en_r, cnt_en_nxt;

  // registered outputs
  logic [63:0] rdata_r, rdata_nxt;
  logic        acc_be_r, acc_be_nxt;
  logic        take_s_r, take_s_nxt;
  logic        take_m_r, take_m_nxt;
  logic [63:0] tpc_r, tpc_nxt;
  logic [63:0] mcause_r, mcause_nxt;
  logic [63:0] tval2_r, tval2_nxt;
  logic        lp_m_we_r, lp_m_we_nxt;
  logic        lp_v_we_r, lp_v_we_nxt;
  logic        lp_wd_r, lp_wd_nxt;
  logic        irq_r, irq_nxt;
  logic [5:0]  irq_cause_r, irq_cause_nxt;
  logic        cnt_ill_r, cnt_ill_nxt;

  // ----------------------------------------------------------------
  // interrupt sources and selection
  // ----------------------------------------------------------------
  logic [1:0]  ctl_sync;
  logic        external_int_pending;
  logic        timer_int_pending;
  logic [15:0] pending;
  logic [15:0] en_mask;
  logic [15:0] pend_wmask;
  logic        sel_hit;
  logic [5:0]  sel_cause;
  logic        int_allowed;

  level_sync #(
    .W (2)
  ) u_ctl_sync (
    .clk    (MCLK),
    .arst_n (ARST_N),
    .d_in   ({EXT_INT_LEVEL, TIMER_INT_LEVEL}),
    .q_out  (ctl_sync)
  );

  assign external_int_pending = ctl_sync[1];
  assign timer_int_pending    = ctl_sync[0];

  always_comb begin
    pending = 16'h0000;
    pending[`IRQ_SOFT_BIT]  = software_int_pending_r;
    pending[`IRQ_TIMER_BIT] = timer_int_pending;
    pending[`IRQ_EXT_BIT]   = external_int_pending;
    pending[`IRQ_COVF_BIT]  = counter_overflow_int_pending_r;
    en_mask = 16'h0000;
    en_mask[`IRQ_SOFT_BIT]  = 1'b1;
    en_mask[`IRQ_TIMER_BIT] = 1'b1;
    en_mask[`IRQ_EXT_BIT]   = 1'b1;
    en_mask[`IRQ_COVF_BIT]  = HAS_COUNTER_OVF;
    pend_wmask = 16'h0000;
    pend_wmask[`IRQ_SOFT_BIT] = 1'b1;
    pend_wmask[`IRQ_COVF_BIT] = HAS_COUNTER_OVF;
  end

  // privilege gate for supervisor interrupts
  assign int_allowed = (PRIV == PRIV_USER) ||
                       ((PRIV == PRIV_SUPV) && gie_r);

  irq_select u_irq_select (
    .req   (pending & enables_r),
    .hit   (sel_hit),
    .cause (sel_cause)
  );

  // ----------------------------------------------------------------
  // control and register state
  // ----------------------------------------------------------------
  logic wr_status, wr_vector, wr_enables, wr_pending, wr_cnten;
  logic trap_s_ok, trap_s_dbl;

  always_comb begin
    wr_status  = CSR_WR && (CSR_ADDR == `CSR_STATUS_IDX);
    wr_vector  = CSR_WR && (CSR_ADDR == `CSR_VECTOR_IDX);
    wr_enables = CSR_WR && (CSR_ADDR == `CSR_ENABLES_IDX);
    wr_pending = CSR_WR && (CSR_ADDR == `CSR_PENDING_IDX);
    wr_cnten   = CSR_WR && (CSR_ADDR == `CSR_CNTEN_IDX);
    trap_s_ok  = TRAP_REQ && TRAP_TO_SUPV && !supervisor_trap_disable_r;
    trap_s_dbl = TRAP_REQ && TRAP_TO_SUPV && supervisor_trap_disable_r;
  end

  always_comb begin
    gie_nxt                     = gie_r;
    spie_nxt                    = spie_r;
    spp_nxt                     = spp_r;
    user_big_endian_nxt         = user_big_endian_r;
    supervisor_trap_disable_nxt = supervisor_trap_disable_r;
    vec_base_nxt                = vec_base_r;
    vec_mode_nxt                = vec_mode_r;
    enables_nxt                 = enables_r;
    cnt_en_nxt                  = cnt_en_r;
    software_int_pending_nxt    = software_int_pending_r;
    counter_overflow_int_pending_nxt = counter_overflow_int_pending_r;
    if (trap_s_ok) begin
      supervisor_trap_disable_nxt = 1'b1;
      spie_nxt = gie_r;
      gie_nxt  = 1'b0;
      spp_nxt  = (PRIV != PRIV_USER);
    end else if (SRET) begin
      supervisor_trap_disable_nxt = 1'b0;
      gie_nxt  = spie_r;
      spie_nxt = 1'b1;
      spp_nxt  = 1'b0;
    end else if (wr_status) begin
      supervisor_trap_disable_nxt = CSR_WDATA[`ST_TDIS_BIT];
      // new trap-disable value gates the enable
      gie_nxt  = CSR_WDATA[`ST_GIE_BIT] & ~CSR_WDATA[`ST_TDIS_BIT];
      spie_nxt = CSR_WDATA[`ST_SPIE_BIT];
      spp_nxt  = CSR_WDATA[`ST_SPP_BIT];
      user_big_endian_nxt = CSR_WDATA[`ST_UEND_BIT];
    end
    if (wr_vector) begin
      vec_base_nxt = CSR_WDATA[63:2];
      if (CSR_WDATA[1:0] == VEC_DIRECT ||
          CSR_WDATA[1:0] == VEC_VECTORED) begin
        vec_mode_nxt = CSR_WDATA[1:0];
      end
    end
    if (wr_enables) begin
      enables_nxt = CSR_WDATA[15:0] & en_mask;
    end
    if (wr_cnten) begin
      cnt_en_nxt = CSR_WDATA[31:0];
    end
    if (wr_pending) begin
      software_int_pending_nxt =
        CSR_WDATA[`IRQ_SOFT_BIT] & pend_wmask[`IRQ_SOFT_BIT];
      counter_overflow_int_pending_nxt =
        CSR_WDATA[`IRQ_COVF_BIT] & pend_wmask[`IRQ_COVF_BIT];
    end
    // hardware set wins over a clearing write
    if (SOFT_INT_SET) begin
      software_int_pending_nxt = 1'b1;
    end
    if (COUNTER_OVF_SET && HAS_COUNTER_OVF) begin
      counter_overflow_int_pending_nxt = 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gie_r                          <= 1'b0;
      spie_r                         <= 1'b0;
      spp_r                          <= 1'b0;
      user_big_endian_r              <= 1'b0;
      supervisor_trap_disable_r      <= 1'b0;
      vec_base_r                     <= 62'(`VEC_RESET >> 2);
      vec_mode_r                     <= VEC_DIRECT;
      enables_r                      <= 16'h0000;
      cnt_en_r                       <= `CNTEN_RESET;
      software_int_pending_r         <= 1'b0;
      counter_overflow_int_pending_r <= 1'b0;
    end else begin
      gie_r                          <= gie_nxt;
      spie_r                         <= spie_nxt;
      spp_r                          <= spp_nxt;
      user_big_endian_r              <= user_big_endian_nxt;
      supervisor_trap_disable_r      <= supervisor_trap_disable_nxt;
      vec_base_r                     <= vec_base_nxt;
      vec_mode_r                     <= vec_mode_nxt;
      enables_r                      <= enables_nxt;
      cnt_en_r                       <= cnt_en_nxt;
      software_int_pending_r         <= software_int_pending_nxt;
      counter_overflow_int_pending_r <= counter_overflow_int_pending_nxt;
    end
  end

  // ----------------------------------------------------------------
  // answers to the pipeline
  // ----------------------------------------------------------------
  logic        lpad_now;
  logic [63:0] base_addr;

  always_comb begin
    lpad_now  = VIRT ? LPAD_VIRT_IN : LPAD_MACH_IN;
    base_addr = {vec_base_r, 2'b00};
    // csr read data, address decode
    rdata_nxt = rdata_r;
    if (CSR_RD) begin
      rdata_nxt = 64'h0000000000000000;
      if (CSR_ADDR == `CSR_STATUS_IDX) begin
        rdata_nxt[`ST_GIE_BIT]  = gie_r;
        rdata_nxt[`ST_SPIE_BIT] = spie_r;
        rdata_nxt[`ST_UEND_BIT] = user_big_endian_r;
        rdata_nxt[`ST_SPP_BIT]  = spp_r;
        rdata_nxt[`ST_LPAD_BIT] = lpad_now;
        rdata_nxt[`ST_TDIS_BIT] = supervisor_trap_disable_r;
      end else if (CSR_ADDR == `CSR_VECTOR_IDX) begin
        rdata_nxt = {vec_base_r, vec_mode_r};
      end else if (CSR_ADDR == `CSR_ENABLES_IDX) begin
        rdata_nxt[15:0] = enables_r;
      end else if (CSR_ADDR == `CSR_PENDING_IDX) begin
        rdata_nxt[15:0] = pending;
      end else if (CSR_ADDR == `CSR_CNTEN_IDX) begin
        rdata_nxt[31:0] = cnt_en_r;
      end
    end
    // landing-pad write routing
    lp_m_we_nxt = wr_status && !VIRT;
    lp_v_we_nxt = wr_status && VIRT;
    lp_wd_nxt   = wr_status ? CSR_WDATA[`ST_LPAD_BIT] : lp_wd_r;
    // endianness of the current access
    acc_be_nxt = acc_be_r;
    if (ACC_REQ) begin
      if (ACC_KIND == ACC_FETCH) begin
        acc_be_nxt = 1'b0;
      end else if (ACC_KIND == ACC_DATA && PRIV == PRIV_USER) begin
        acc_be_nxt = user_big_endian_r;
      end else begin
        acc_be_nxt = SUPV_BIG_ENDIAN;
      end
    end
    // trap delivery
    take_s_nxt = trap_s_ok;
    take_m_nxt = trap_s_dbl;
    tpc_nxt    = tpc_r;
    mcause_nxt = mcause_r;
    tval2_nxt  = tval2_r;
    if (trap_s_ok) begin
      if (vec_mode_r == VEC_VECTORED && TRAP_IS_INT) begin
        tpc_nxt = base_addr + {56'h0, TRAP_CODE, 2'b00};
      end else begin
        tpc_nxt = base_addr;
      end
    end
    if (trap_s_dbl) begin
      mcause_nxt = `DOUBLE_TRAP_CODE;
      tval2_nxt  = {TRAP_IS_INT, 57'h0, TRAP_CODE};
    end
    // interrupt evaluation, every cycle
    irq_nxt       = sel_hit && int_allowed;
    irq_cause_nxt = sel_cause;
    // user counter gate
    cnt_ill_nxt = CNT_RD && (PRIV == PRIV_USER) &&
                  !(cnt_en_r[CNT_INDEX] && MACH_CNT_EN[CNT_INDEX]);
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_r     <= 64'h0000000000000000;
      acc_be_r    <= 1'b0;
      take_s_r    <= 1'b0;
      take_m_r    <= 1'b0;
      tpc_r       <= 64'h0000000000000000;
      mcause_r    <= 64'h0000000000000000;
      tval2_r     <= 64'h0000000000000000;
      lp_m_we_r   <= 1'b0;
      lp_v_we_r   <= 1'b0;
      lp_wd_r     <= 1'b0;
      irq_r       <= 1'b0;
      irq_cause_r <= 6'h00;
      cnt_ill_r   <= 1'b0;
    end else begin
      rdata_r     <= rdata_nxt;
      acc_be_r    <= acc_be_nxt;
      take_s_r    <= take_s_nxt;
      take_m_r    <= take_m_nxt;
      tpc_r       <= tpc_nxt;
      mcause_r    <= mcause_nxt;
      tval2_r     <= tval2_nxt;
      lp_m_we_r   <= lp_m_we_nxt;
      lp_v_we_r   <= lp_v_we_nxt;
      lp_wd_r     <= lp_wd_nxt;
      irq_r       <= irq_nxt;
      irq_cause_r <= irq_cause_nxt;
      cnt_ill_r   <= cnt_ill_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign CSR_RDATA            = rdata_r;
  assign ACC_BIG_ENDIAN       = acc_be_r;
  assign TRAP_TAKE_SUPV       = take_s_r;
  assign TRAP_TAKE_MACH       = take_m_r;
  assign TRAP_PC              = tpc_r;
  assign MACH_CAUSE           = mcause_r;
  assign SECONDARY_TRAP_VALUE = tval2_r;
  assign LPAD_MACH_WE         = lp_m_we_r;
  assign LPAD_VIRT_WE         = lp_v_we_r;
  assign LPAD_WDATA           = lp_wd_r;
  assign IRQ_TAKE             = irq_r;
  assign IRQ_CAUSE            = irq_cause_r;
  assign CNT_ILLEGAL          = cnt_ill_r;

endmodule : supervisor_trap_interrupt_ctrl

/* File: test/strap_far_side.sv */
// far-side model: interrupt controller levels and set pulses
// assumes requests from the bench on the core clock
`timescale 1ns/100ps
module strap_far_side (
  // clock and requests
  input  wire logic clk,
  input  wire logic ext_req,
  input  wire logic tmr_req,
  input  wire logic soft_req,
  input  wire logic ovf_req,
  // lines into the block
  output logic      ext_lvl,
  output logic      tmr_lvl,
  output logic      soft_set,
  output logic      ovf_set
);
  // ------------------------------------------
  // levels off the edge, pulses on it
  // ------------------------------------------
  initial {ext_lvl, tmr_lvl, soft_set, ovf_set} = '0;
  always @(posedge clk) begin
    ext_lvl  <= #1.3 ext_req;
    tmr_lvl  <= #2.1 tmr_req;
    soft_set <= soft_req;
    ovf_set  <= ovf_req;
  end
endmodule : strap_far_side

/* File: test/strap_checker_assertions.sv */
// assertions on the ports of the supervisor trap and interrupt block
// assumes binding into the design's top module, one clock domain
`timescale 1ns/100ps
module strap_checker (
  // clock and reset
  input wire logic        MCLK,
  input wire logic        ARST_N,
  // watched ports
  input wire logic        ACC_REQ,
  input wire logic [1:0]  ACC_KIND,
  input wire logic        SUPV_BIG_ENDIAN,
  input wire logic        ACC_BIG_ENDIAN,
  input wire logic        TRAP_REQ,
  input wire logic        TRAP_TO_SUPV,
  input wire logic        TRAP_TAKE_SUPV,
  input wire logic        TRAP_TAKE_MACH,
  input wire logic [63:0] MACH_CAUSE,
  input wire logic        IRQ_TAKE,
  input wire logic        CNT_RD,
  input wire logic [1:0]  PRIV,
  input wire logic        CNT_ILLEGAL,
  input wire logic        VIRT,
  input wire logic        LPAD_MACH_WE,
  input wire logic        LPAD_VIRT_WE
);
  // ------------------------------------------
  // properties
  // ------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);
  property p_fetch;
    ACC_REQ && ACC_KIND == 2'h0 |=> !ACC_BIG_ENDIAN;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch endian");
  property p_impl;
    ACC_REQ && ACC_KIND == 2'h2 |=> ACC_BIG_ENDIAN == $past(SUPV_BIG_ENDIAN);
  endproperty
  a_impl: assert property (p_impl) else $error("implicit endian");
  property p_trap;
    TRAP_REQ && TRAP_TO_SUPV |=> TRAP_TAKE_SUPV != TRAP_TAKE_MACH;
  endproperty
  a_trap: assert property (p_trap) else $error("trap answer");
  property p_idle;
    !(TRAP_REQ && TRAP_TO_SUPV) |=> !TRAP_TAKE_SUPV && !TRAP_TAKE_MACH;
  endproperty
  a_idle: assert property (p_idle) else $error("stray take");
  property p_mcause;
    TRAP_TAKE_MACH |-> MACH_CAUSE == 64'h10 && !TRAP_TAKE_SUPV;
  endproperty
  a_mcause: assert property (p_mcause) else $error("double trap");
  property p_cnt;
    CNT_RD && PRIV != 2'h0 |=> !CNT_ILLEGAL;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter gate");
  property p_lpad;
    LPAD_MACH_WE || LPAD_VIRT_WE |->
      LPAD_VIRT_WE == $past(VIRT) && LPAD_MACH_WE != $past(VIRT);
  endproperty
  a_lpad: assert property (p_lpad) else $error("lpad route");
  property p_mquiet;
    PRIV == 2'h3 [*3] |-> !IRQ_TAKE;
  endproperty
  a_mquiet: assert property (p_mquiet) else $error("irq in m");
  c_mach: cover property (TRAP_TAKE_MACH);
  c_irq: cover property (IRQ_TAKE);
  c_virt: cover property (LPAD_VIRT_WE);
endmodule : strap_checker
bind supervisor_trap_interrupt_ctrl strap_checker strap_checker_inst (
  .MCLK, .ARST_N, .ACC_REQ, .ACC_KIND, .SUPV_BIG_ENDIAN, .ACC_BIG_ENDIAN,
  .TRAP_REQ, .TRAP_TO_SUPV, .TRAP_TAKE_SUPV, .TRAP_TAKE_MACH, .MACH_CAUSE,
  .IRQ_TAKE, .CNT_RD, .PRIV, .CNT_ILLEGAL, .VIRT, .LPAD_MACH_WE,
  .LPAD_VIRT_WE);

/* File: test/supervisor_trap_interrupt_ctrl_bench.sv */
// self-checking bench for the supervisor trap and interrupt block
// assumes package, header, far-side model and checker are compiled
`timescale 1ns/100ps
`include "strap_regs.svh"
module supervisor_trap_interrupt_ctrl_bench import strap_pkg::*;;
  logic        MCLK, ARST_N, CSR_WR, CSR_RD, VIRT, SUPV_BIG_ENDIAN, ACC_REQ;
  logic        TRAP_REQ, TRAP_TO_SUPV, TRAP_IS_INT, SRET, CNT_RD, CNT_ILLEGAL;
  logic        ACC_BIG_ENDIAN, TRAP_TAKE_SUPV, TRAP_TAKE_MACH, IRQ_TAKE;
  logic        LPAD_MACH_WE, LPAD_VIRT_WE, LPAD_WDATA, EXT_INT_LEVEL;
  logic        TIMER_INT_LEVEL, SOFT_INT_SET, COUNTER_OVF_SET, prb;
  logic        LPAD_MACH_IN, LPAD_VIRT_IN;
  logic        ext_req, tmr_req, soft_req, ovf_req, rd_d, acc_d, cnt_d, prb_d;
  logic [1:0]  PRIV, ACC_KIND;
  logic [4:0]  CNT_INDEX;
  logic [5:0]  TRAP_CODE, IRQ_CAUSE, code;
  logic [7:0]  CSR_ADDR;
  logic [31:0] MACH_CNT_EN, cen;
  logic [63:0] CSR_WDATA, CSR_RDATA, TRAP_PC, MACH_CAUSE, SECONDARY_TRAP_VALUE;
  logic [63:0] base, q[$];
  int          failures, compares;
  supervisor_trap_interrupt_ctrl supervisor_trap_interrupt_ctrl_inst (
    .MCLK, .ARST_N, .CSR_WR, .CSR_RD, .CSR_ADDR, .CSR_WDATA, .CSR_RDATA,
    .PRIV, .VIRT, .SUPV_BIG_ENDIAN, .ACC_REQ, .ACC_KIND, .ACC_BIG_ENDIAN,
    .TRAP_REQ, .TRAP_TO_SUPV, .TRAP_IS_INT, .TRAP_CODE, .SRET,
    .TRAP_TAKE_SUPV, .TRAP_TAKE_MACH, .TRAP_PC, .MACH_CAUSE,
    .SECONDARY_TRAP_VALUE, .LPAD_MACH_IN, .LPAD_VIRT_IN,
    .LPAD_MACH_WE, .LPAD_VIRT_WE, .LPAD_WDATA, .EXT_INT_LEVEL,
    .TIMER_INT_LEVEL, .SOFT_INT_SET, .COUNTER_OVF_SET, .IRQ_TAKE, .IRQ_CAUSE,
    .CNT_RD, .CNT_INDEX, .MACH_CNT_EN, .CNT_ILLEGAL);
  strap_far_side strap_far_side_inst (.clk(MCLK), .ext_req, .tmr_req,
    .soft_req, .ovf_req, .ext_lvl(EXT_INT_LEVEL), .tmr_lvl(TIMER_INT_LEVEL),
    .soft_set(SOFT_INT_SET), .ovf_set(COUNTER_OVF_SET));
  // ------------------------------------------
  // tasks
  // ------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    if (failures == 0 && compares > 0 && q.size() == 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic fire;
    @(posedge MCLK);
    {CSR_WR, CSR_RD, TRAP_REQ, SRET, ACC_REQ, CNT_RD, prb} <= '0;
    {soft_req, ovf_req} <= 2'b00;
    @(posedge MCLK);
  endtask : fire
  task automatic csr(input logic w, input logic [7:0] a, logic [63:0] d);
    if (w && a == `CSR_STATUS_IDX) q.push_back(64'(d[`ST_LPAD_BIT]));
    CSR_WR <= w;
    CSR_RD <= !w;
    CSR_ADDR <= a;
    CSR_WDATA <= d;
    fire;
  endtask : csr
  task automatic rd(input logic [7:0] a, logic [63:0] e);
    q.push_back(e);
    csr(1'b0, a, 64'h0);
  endtask : rd
  task automatic probe(input logic [6:0] e);
    q.push_back({57'h0, e});
    prb <= 1'b1;
    fire;
  endtask : probe
  task automatic trap(input logic i, logic [63:0] e);
    q.push_back(e);
    TRAP_REQ <= 1'b1;
    TRAP_TO_SUPV <= 1'b1;
    TRAP_IS_INT <= i;
    TRAP_CODE <= code;
    fire;
  endtask : trap
  // ------------------------------------------
  // result watcher
  // ------------------------------------------
  always @(posedge MCLK) begin
    if (rd_d) check("csr", CSR_RDATA, q.pop_front());
    if (TRAP_TAKE_SUPV === 1'b1) check("pc", TRAP_PC, q.pop_front());
    if (TRAP_TAKE_MACH === 1'b1)
      check("tval2", SECONDARY_TRAP_VALUE, q.pop_front());
    if (acc_d) check("endian", 64'(ACC_BIG_ENDIAN), q.pop_front());
    if (cnt_d) check("illegal", 64'(CNT_ILLEGAL), q.pop_front());
    if (prb_d)
      check("irq", {57'h0, IRQ_TAKE, IRQ_TAKE ? IRQ_CAUSE : 6'h0},
            q.pop_front());
    if (LPAD_MACH_WE === 1'b1 || LPAD_VIRT_WE === 1'b1)
      check("lpad", 64'(LPAD_WDATA), q.pop_front());
    rd_d <= CSR_RD;
    acc_d <= ACC_REQ;
    cnt_d <= CNT_RD;
    prb_d <= prb;
  end
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  initial begin
    repeat (3000) @(posedge MCLK);
    failures++;
    conclude;
  end
  initial begin
    {ARST_N, CSR_WR, CSR_RD, VIRT, SUPV_BIG_ENDIAN, ACC_REQ, TRAP_REQ} = '0;
    {TRAP_TO_SUPV, TRAP_IS_INT, SRET, CNT_RD, prb, rd_d, acc_d, cnt_d} = '0;
    {ext_req, tmr_req, soft_req, ovf_req, prb_d, PRIV, ACC_KIND} = '0;
    {CNT_INDEX, TRAP_CODE, CSR_ADDR, CSR_WDATA, MACH_CNT_EN} = '0;
    {LPAD_MACH_IN, LPAD_VIRT_IN} = 2'b01;
    void'($urandom(32'hB943));
    repeat (8) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    for (int a = 0; a < 6; a++) rd(8'(a), 64'h0);
    csr(1'b1, `CSR_ENABLES_IDX, '1);
    rd(`CSR_ENABLES_IDX, 64'h2222);
    csr(1'b1, `CSR_PENDING_IDX, '1);
    rd(`CSR_PENDING_IDX, 64'h2002);
    csr(1'b1, `CSR_PENDING_IDX, 64'h0);
    rd(`CSR_PENDING_IDX, 64'h0);
    {ext_req, tmr_req, soft_req, ovf_req} <= 4'hF;
    fire;
    repeat (6) @(posedge MCLK);
    rd(`CSR_PENDING_IDX, 64'h2222);
    probe(7'h49);
    PRIV <= PRIV_MACH;
    repeat (4) @(posedge MCLK);
    probe(7'h00);
    PRIV <= PRIV_USER;
    ext_req <= 1'b0;
    repeat (6) @(posedge MCLK);
    probe(7'h41);
    csr(1'b1, `CSR_PENDING_IDX, 64'h2000);
    probe(7'h45);
    tmr_req <= 1'b0;
    repeat (6) @(posedge MCLK);
    probe(7'h4D);
    PRIV <= PRIV_SUPV;
    csr(1'b1, `CSR_STATUS_IDX, 64'h0);
    probe(7'h00);
    csr(1'b1, `CSR_STATUS_IDX, 64'h2);
    probe(7'h4D);
    csr(1'b1, `CSR_STATUS_IDX, 64'h1000002);
    rd(`CSR_STATUS_IDX, 64'h1000000);
    csr(1'b1, `CSR_STATUS_IDX, 64'h2);
    rd(`CSR_STATUS_IDX, 64'h2);
    csr(1'b1, `CSR_PENDING_IDX, 64'h0);
    {PRIV, VIRT, SUPV_BIG_ENDIAN} <= {PRIV_USER, 2'h3};
    csr(1'b1, `CSR_STATUS_IDX, 64'h800040);
    rd(`CSR_STATUS_IDX, 64'h800040);
    for (int k = 0; k < 4; k++) begin
      q.push_back(64'(k == 1 || k == 2));
      ACC_KIND <= 2'(k % 3);
      ACC_REQ <= 1'b1;
      VIRT <= k < 3;
      if (k == 3) csr(1'b1, `CSR_STATUS_IDX, 64'h0);
      fire;
    end
    base = {$urandom, $urandom} & 64'hFFFF_FFFF_FFFF_FFFC;
    code = 6'($urandom);
    csr(1'b1, `CSR_VECTOR_IDX, base | 64'h1);
    trap(1'b1, base + {code, 2'h0});
    trap(1'b1, {1'b1, 57'h0, code});
    SRET <= 1'b1;
    fire;
    trap(1'b0, base);
    SRET <= 1'b1;
    csr(1'b1, `CSR_VECTOR_IDX, base | 64'h2);
    rd(`CSR_VECTOR_IDX, base | 64'h1);
    trap(1'b1, base + {code, 2'h0});
    SRET <= 1'b1;
    csr(1'b1, `CSR_VECTOR_IDX, base);
    trap(1'b1, base);
    MACH_CNT_EN <= $urandom;
    cen = $urandom;
    csr(1'b1, `CSR_CNTEN_IDX, {32'h0, cen});
    rd(`CSR_CNTEN_IDX, {32'h0, cen});
    for (int i = 0; i < 9; i++) begin
      if (i == 8) PRIV <= PRIV_SUPV;
      CNT_INDEX <= 5'($urandom);
      @(posedge MCLK);
      q.push_back(64'(i < 8 && !(cen[CNT_INDEX] && MACH_CNT_EN[CNT_INDEX])));
      CNT_RD <= 1'b1;
      fire;
    end
    repeat (3) @(posedge MCLK);
    conclude;
  end
endmodule : supervisor_trap_interrupt_ctrl_bench
